// ### dsr_pkg.sv
// Shared constants and carrier types for the command spacing block
package dsr_pkg;

  // ----------------------------------------------------------------
  // Clock and spacing figures
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS          = 20000;
  localparam int ROW_PRECHARGE_TIME_PS  = 15000;
  localparam int WRITE_TO_READ_GAP      = 2;
  localparam int CLK_GATE_MIN_HOLD      = 3;
  localparam int POWERDOWN_EXIT_DELAY   = 2;
  // Round up: a least time never shrinks below its figure
  localparam int PRECHARGE_CYCLE_COUNT  =
    (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Mode configuration layout
  // ----------------------------------------------------------------
  localparam int MODE_WIDTH          = 14;
  localparam int MODE_STROBE_BIT     = 10;
  localparam int MODE_WR_LSB         = 11;
  localparam int MODE_WR_WIDTH       = 3;
  localparam logic [13:0] MODE_RESET = 14'h0000;
  localparam int CNT_WIDTH           = 5;

  typedef enum logic [3:0] {
    DSR_CMD_NOP,
    DSR_CMD_ACTIVATE,
    DSR_CMD_READ,
    DSR_CMD_WRITE,
    DSR_CMD_WRITE_AP,
    DSR_CMD_PRECHARGE,
    DSR_CMD_MODE_LOAD,
    DSR_CMD_PD_ENTER,
    DSR_CMD_PD_EXIT
  } dsr_cmd_code_t;

  typedef struct packed {
    logic                  valid;
    dsr_cmd_code_t         code;
    logic [MODE_WIDTH-1:0] addr;
  } dsr_cmd_t;

  typedef struct packed {
    logic accept;
    logic reject;
    logic wtr_err;
    logic cke_err;
    logic read_suspect;
    logic strobe_single;
  } dsr_status_t;

endpackage

// ### dsr_spacing.sv
// Device-side command spacing tracker: counts input clock edges between commands
//
// How it works
// - Nanosecond spacing rounds up to cycles
// - Accept command once cycle count elapses
// - Cycle parameters count actual clock edges
// - Activate allowed two cycles after exit
// - Mode bit ten set: single-ended strobe
// - Mode bit ten clear: differential strobe
`timescale 1ns/1ps
`default_nettype none

module dsr_spacing
  import dsr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire dsr_cmd_t    cmd_in,
  input  wire logic        cke_in,
  input  wire logic        wr_burst_end,
  input  wire logic        wr_window_err,
  output var  dsr_status_t status
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MODE_WIDTH-1:0] mode_cfg;
    logic [CNT_WIDTH-1:0]  wtr_cnt;
    logic [CNT_WIDTH-1:0]  cke_cnt;
    logic [CNT_WIDTH-1:0]  xp_cnt;
    logic [CNT_WIDTH-1:0]  dal_cnt;
    logic                  dal_armed;
    logic                  cke_level;
    logic                  corrupt;
    logic                  burst_err;
    dsr_status_t           stat;
  } dsr_state_t;

  localparam logic [CNT_WIDTH-1:0] WTR_LOAD = CNT_WIDTH'(WRITE_TO_READ_GAP - 1);
  localparam logic [CNT_WIDTH-1:0] CKE_LOAD = CNT_WIDTH'(CLK_GATE_MIN_HOLD - 1);
  localparam logic [CNT_WIDTH-1:0] XP_LOAD  = CNT_WIDTH'(POWERDOWN_EXIT_DELAY - 1);
  localparam logic [CNT_WIDTH-1:0] RP_CYC   = CNT_WIDTH'(PRECHARGE_CYCLE_COUNT);

  dsr_state_t state_reg;
  dsr_state_t state_next;

  logic [MODE_WR_WIDTH-1:0] wr_recovery;
  logic                     blocked;
  logic                     is_read;
  logic                     is_act;

  assign wr_recovery = state_reg.mode_cfg[MODE_WR_LSB +: MODE_WR_WIDTH];
  assign is_read     = cmd_in.valid && (cmd_in.code == DSR_CMD_READ);
  assign is_act      = cmd_in.valid && (cmd_in.code == DSR_CMD_ACTIVATE);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.stat.accept  = 1'b0;
    state_next.stat.reject  = 1'b0;
    state_next.stat.wtr_err = 1'b0;
    state_next.stat.cke_err = 1'b0;

    // Counters tick on every edge, never on elapsed time, so a jittery
    // short period still counts as a full cycle
    if (state_reg.wtr_cnt != '0) begin
      state_next.wtr_cnt = state_reg.wtr_cnt - 1'b1;
    end
    if (state_reg.xp_cnt != '0) begin
      state_next.xp_cnt = state_reg.xp_cnt - 1'b1;
    end
    if (state_reg.dal_cnt != '0) begin
      state_next.dal_cnt = state_reg.dal_cnt - 1'b1;
    end

    // Clock enable must stay put until three edges have sampled it
    if (cke_in != state_reg.cke_level) begin
      state_next.cke_level = cke_in;
      state_next.cke_cnt   = CKE_LOAD;
      if (state_reg.cke_cnt != '0) begin
        state_next.stat.cke_err = 1'b1;
      end
    end else if (state_reg.cke_cnt != '0) begin
      state_next.cke_cnt = state_reg.cke_cnt - 1'b1;
    end

    // Gap is measured from the burst's last data, not from the command
    if (wr_burst_end) begin
      state_next.wtr_cnt = WTR_LOAD;
      if (state_reg.dal_armed) begin
        state_next.dal_armed = 1'b0;
        // Recovery field plus rounded-up precharge cycles, less the
        // edge that closes this burst
        state_next.dal_cnt = CNT_WIDTH'(wr_recovery) + RP_CYC - 1'b1;
      end
    end

    // A bad beat anywhere in the burst marks its data; only a burst with
    // no bad beat at all heals earlier corruption
    if (wr_burst_end) begin
      state_next.corrupt   = wr_window_err || state_reg.burst_err;
      state_next.burst_err = 1'b0;
    end else if (wr_window_err) begin
      state_next.corrupt   = 1'b1;
      state_next.burst_err = 1'b1;
    end

    blocked = 1'b0;
    if (is_read && (state_reg.wtr_cnt != '0 || wr_burst_end)) begin
      blocked                 = 1'b1;
      state_next.stat.wtr_err = 1'b1;
    end
    if (is_act && (state_reg.xp_cnt != '0 || state_reg.dal_cnt != '0 || state_reg.dal_armed)) begin
      blocked = 1'b1;
    end

    if (cmd_in.valid && cmd_in.code != DSR_CMD_NOP) begin
      // Once the count has run out the command is taken, whatever the
      // actual elapsed time was
      state_next.stat.accept = !blocked;
      state_next.stat.reject = blocked;
      if (!blocked) begin
        unique case (cmd_in.code)
          DSR_CMD_MODE_LOAD: begin
            state_next.mode_cfg = cmd_in.addr;
          end
          DSR_CMD_PD_EXIT: begin
            state_next.xp_cnt = XP_LOAD;
          end
          DSR_CMD_WRITE_AP: begin
            state_next.dal_armed = 1'b1;
          end
          DSR_CMD_READ: begin
            state_next.stat.read_suspect = state_reg.corrupt;
          end
          default: begin
          end
        endcase
      end
    end

    state_next.stat.strobe_single = state_next.mode_cfg[MODE_STROBE_BIT];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg          <= '0;
      state_reg.mode_cfg <= MODE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.stat;

endmodule

`default_nettype wire

// ### dsr_spacing_assertions.sv
// Port checks for the command spacing block
`timescale 1ns/1ps
`default_nettype none
module dsr_spacing_chk
  import dsr_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire dsr_cmd_t    cmd_in,
  input wire logic        cke_in,
  input wire logic        wr_burst_end,
  input wire logic        wr_window_err,
  input wire dsr_status_t status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  dsr_cmd_code_t c;
  assign c = cmd_in.valid ? cmd_in.code : DSR_CMD_NOP;
  sequence s_wtr; wr_burst_end ##1 c == DSR_CMD_READ; endsequence
  sequence s_exit; c == DSR_CMD_PD_EXIT ##1 c == DSR_CMD_ACTIVATE; endsequence
  sequence s_load; c == DSR_CMD_MODE_LOAD ##1 c != DSR_CMD_MODE_LOAD; endsequence
  chk_one_answer: assert property (c != DSR_CMD_NOP |=> status.accept != status.reject)
    else $error("answer not single");
  chk_idle_quiet: assert property (c == DSR_CMD_NOP |=> !status.accept && !status.reject)
    else $error("answer without command");
  chk_wtr_block: assert property (s_wtr |=> status.reject && status.wtr_err)
    else $error("early read taken");
  chk_exit_block: assert property (s_exit |=> status.reject)
    else $error("early activate taken");
  chk_strobe_mode: assert property (s_load |=> status.strobe_single == $past(cmd_in.addr[MODE_STROBE_BIT], 2))
    else $error("strobe mode wrong");
  // Reset-edge changes are skipped: the pre-change level is not yet known there
  chk_cke_recheck: assert property ($past(rst_n) && $changed(cke_in) ##1 $changed(cke_in) |=> status.cke_err)
    else $error("gate change not flagged");
endmodule
`default_nettype wire

// ### dsr_ctl_model.sv
// Controller model: one command slot per clock
`timescale 1ns/1ps
`default_nettype none
module dsr_ctl_model
  import dsr_pkg::*;
(
  input  wire logic     ref_clk,
  output var  dsr_cmd_t cmd_in,
  output var  logic     cke_in,
  output var  logic     wr_burst_end,
  output var  logic     wr_window_err
);
  initial {cmd_in, cke_in, wr_burst_end, wr_window_err} = '0;
  // Spacing is chosen by the caller, so refusals can be provoked on purpose
  task automatic slot(input dsr_cmd_code_t c, input logic [13:0] a, input logic b, input logic k, input logic w);
    @(posedge ref_clk);
    #1;
    cmd_in = '{c != DSR_CMD_NOP, c, a};
    wr_burst_end = b;
    cke_in = k;
    wr_window_err = w;
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the command spacing block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dsr_pkg::*;
;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        ck, be, we, cke, ap, bad, wb, cl, ea, er, ew, ek, es, ss, lm;
  logic [5:0]  x, m;
  dsr_cmd_t    cmd;
  dsr_status_t st;
  int          err_total = 0, samples_checked = 0, cyc = 0, n = 0, bea = -9, exa = -9, cha = -9, rec = 0, wr = 0;
  dsr_ctl_model u_dsr_ctl_model (.ref_clk(ref_clk), .cmd_in(cmd), .cke_in(cke), .wr_burst_end(be),
    .wr_window_err(we));
  dsr_spacing u_dsr_spacing (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_in(cmd), .cke_in(cke), .wr_burst_end(be),
    .wr_window_err(we), .status(st));
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (++cyc == 500) err_total++;
    if (cyc == 500) finish_test();
  end
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic s(input dsr_cmd_code_t c, input logic [13:0] a = 14'($urandom), input logic b = 0, input logic w = 0);
    u_dsr_ctl_model.slot(c, a, b, ck, w);
    // Strobe latency after a load is the design's choice, so it is masked there
    m = lm ? 6'h3E : 6'h3F;
    x = {ea, er, ew, ek, es, ss} & m;
    samples_checked++;
    if ((st & m) !== x) begin
      err_total++;
      $display("BAD status exp %b got %b", x, st & m);
    end
    n++;
    if (w) wb = 1;
    if (b) bea = n;
    if (b && ap) rec = n + wr + PRECHARGE_CYCLE_COUNT;
    if (b) {ap, bad, wb} = {1'h0, wb, 1'h0};
    ek = ck != cl && n < cha + CLK_GATE_MIN_HOLD;
    if (ck != cl) cha = n;
    cl = ck;
    ew = c == DSR_CMD_READ && n < bea + WRITE_TO_READ_GAP;
    er = ew || c == DSR_CMD_ACTIVATE && (n < exa + POWERDOWN_EXIT_DELAY || ap || n < rec);
    ea = c != DSR_CMD_NOP && !er;
    lm = ea && c == DSR_CMD_MODE_LOAD;
    if (lm) wr = a[13:11];
    if (lm) ss = a[MODE_STROBE_BIT];
    if (ea && c == DSR_CMD_READ) es = bad;
    if (ea && c == DSR_CMD_PD_EXIT) exa = n;
    if (ea && c == DSR_CMD_WRITE_AP) ap = 1;
  endtask
  initial begin
    {ck, ap, bad, wb, cl, ea, er, ew, ek, es, ss, lm} = '0;
    void'($urandom(32'h03C5));
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'h1;
    for (int i = 0; i < 2; i++) begin
      s(DSR_CMD_MODE_LOAD, {3'($urandom), 1'(i), 10'($urandom)});
      s(DSR_CMD_NOP);
    end
    s(DSR_CMD_READ, , 1);
    for (int g = 0; g < 3; g++) begin
      s(DSR_CMD_WRITE);
      s(DSR_CMD_NOP, , 1);
      repeat (g) s(DSR_CMD_NOP);
      s(DSR_CMD_READ);
    end
    s(DSR_CMD_PD_ENTER);
    s(DSR_CMD_PD_EXIT);
    repeat (2) s(DSR_CMD_ACTIVATE);
    s(DSR_CMD_MODE_LOAD);
    s(DSR_CMD_WRITE_AP);
    s(DSR_CMD_ACTIVATE);
    s(DSR_CMD_NOP, , 1);
    repeat (9) s(DSR_CMD_ACTIVATE);
    s(DSR_CMD_PRECHARGE);
    for (int k = 0; k < 2; k++) begin
      s(DSR_CMD_WRITE);
      s(DSR_CMD_NOP, , 0, !k);
      s(DSR_CMD_NOP, , 1);
      s(DSR_CMD_NOP);
      s(DSR_CMD_READ);
    end
    for (int i = 0; i < 10; i++) begin
      ck = 1'(10'h231 >> i);
      s(DSR_CMD_NOP);
    end
    s(DSR_CMD_NOP);
    finish_test();
  end
endmodule
bind dsr_spacing dsr_spacing_chk u_dsr_spacing_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_in(cmd_in),
  .cke_in(cke_in), .wr_burst_end(wr_burst_end), .wr_window_err(wr_window_err), .status(status));
`default_nettype wire
